// >>> hdl/anpcs_pkg.sv
// Package for the auto-negotiation next-page and coding-sublayer status bank.
// Assumes byte addressing on an 8/16-bit CPU bus, word registers at even addresses.
package anpcs_pkg;
  // Byte addresses of the low byte of each register
  localparam logic [7:0] ADDR_EXPANSION    = 8'h5c;
  localparam logic [7:0] ADDR_NP_TRANSMIT  = 8'h5e;
  localparam logic [7:0] ADDR_PARTNER_NP   = 8'h60;
  localparam logic [7:0] ADDR_EXT_ABILITY  = 8'h6e;
  localparam logic [7:0] ADDR_CODING_STAT  = 8'h70;

  // Page field positions
  localparam int MORE_PAGES_BIT   = 15;
  localparam int MESSAGE_PAGE_BIT = 13;
  localparam int COMPLY_ACK_BIT   = 12;
  localparam int TOGGLE_BIT       = 11;
  localparam int ENCODING_MSB     = 10;

  // Bits of the next-page transmit register that software may write
  localparam logic [15:0] NP_TRANSMIT_WMASK = 16'hb7ff;

  // Expansion register fields
  localparam int NEXT_PAGE_RX_BIT  = 7;
  localparam int NEXT_PAGE_ABL_BIT = 2;
  localparam int PAGE_RECEIVED_BIT = 1;

  // Coding-sublayer status fields
  localparam int SYNC_ACQUIRED_BIT  = 5;
  localparam int PARTNER_PAUSE_BIT  = 1;
  localparam int RX_FLOW_CTRL_BIT   = 0;

  // Extended ability: 1000BASE-X full duplex only, all else zero
  localparam logic [15:0] EXT_ABILITY_VALUE = 16'h8000;

  // Reset values
  localparam logic [15:0] NP_TRANSMIT_RESET = 16'h0000;
  localparam logic [15:0] PARTNER_NP_RESET  = 16'h0000;
  localparam logic [15:0] CODING_STAT_RESET = 16'h0000;
endpackage

// >>> hdl/anpcs_byte_stage.sv
// Byte staging for 16-bit register writes arriving over an 8-bit bus.
// Assumes the host writes the low byte first, then the high byte.
`timescale 1ns/1ps
`default_nettype none
module anpcs_byte_stage (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        lowWrite,
  input  wire logic        highWrite,
  input  wire logic [7:0]  byteIn,
  output logic      [7:0]  lowByte,
  output logic             lowPending
);
  typedef struct packed {
    logic [7:0] held;
    logic       pending;
  } anpcs_stage_s;

  anpcs_stage_s st;
  anpcs_stage_s next_st;

  // Low byte waits here; the high write commits both halves together
  always_comb begin
    next_st = st;
    if (lowWrite) begin
      next_st.held    = byteIn;
      next_st.pending = 1'b1;
    end else if (highWrite) begin
      next_st.pending = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lowByte    = st.held;
  assign lowPending = st.pending;
endmodule
`default_nettype wire

// >>> hdl/anpcs_regs.sv
// Per-port auto-negotiation next-page and coding-sublayer status registers.
// Assumes a byte-addressed CPU bus of 8 or 16 bits and a page engine on the link side.
// The host holds address and data with its one-cycle strobe.
// The link side gives one strobe per complete partner page and per exchanged page.
`timescale 1ns/1ps
`default_nettype none
module anpcs_regs (
  input  wire logic        clk,
  input  wire logic        rstn,
  // CPU bus
  input  wire logic        bus16,
  input  wire logic [7:0]  cpuAddr,
  input  wire logic [15:0] cpuWrData,
  input  wire logic        cpuWr,
  input  wire logic        cpuRd,
  output logic      [15:0] cpuRdData,
  // Page engine
  input  wire logic        pageRxValid,
  input  wire logic [15:0] pageRxWord,
  input  wire logic        pageRxIsNext,
  input  wire logic        txPageSent,
  input  wire logic        exchangeStart,
  input  wire logic        baseToggle,
  output logic      [15:0] txPage,
  // Coding sublayer
  input  wire logic        gigabitCodingSublayer,
  input  wire logic        syncAcquired,
  input  wire logic        partnerPauseStatus,
  input  wire logic        rxFlowControlStatus
);
  // All registered state of the bank in one word, except the staged low byte and its pending flag held in u_stage
  typedef struct packed {
    logic [15:0] npTransmit;
    logic [15:0] partnerNp;
    logic [15:0] codingStat;
    logic        pageReceived;
    logic        nextPageRx;
    logic        toggle;
    logic [15:0] rdData;
  } anpcs_regs_s;

  anpcs_regs_s st;
  anpcs_regs_s next_st;

  // Decode, staging and data-path signals
  logic [7:0]  stagedLow;
  logic        stagedPending;
  logic        wordAddr0;
  logic        hitTx;
  logic        hitExp;
  logic        hitPartner;
  logic        hitExtAbility;
  logic        hitStatus;
  logic        hitTxLow8;
  logic        hitTxHigh8;
  logic        commitTx;
  logic        hitExpRead;
  logic [15:0] rdWord;
  logic [15:0] laneWord;
  logic [15:0] wrWord;

  // True when the access targets the word at a given even base address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base);
    hit = (addr[7:1] == base[7:1]);
  endfunction

  // Byte lane and word decode; one hit per register, shared by the mux and the clears
  assign wordAddr0     = ~cpuAddr[0];
  assign hitTx         = hit(cpuAddr, anpcs_pkg::ADDR_NP_TRANSMIT);
  assign hitExp        = hit(cpuAddr, anpcs_pkg::ADDR_EXPANSION);
  assign hitPartner    = hit(cpuAddr, anpcs_pkg::ADDR_PARTNER_NP);
  assign hitExtAbility = hit(cpuAddr, anpcs_pkg::ADDR_EXT_ABILITY);
  assign hitStatus     = hit(cpuAddr, anpcs_pkg::ADDR_CODING_STAT);

  // 8-bit writes to the transmit page, split by byte address
  assign hitTxLow8     = cpuWr & ~bus16 & hitTx & wordAddr0;
  assign hitTxHigh8    = cpuWr & ~bus16 & hitTx & ~wordAddr0;

  // A word commits on a 16-bit write, or on an 8-bit high byte after its low byte;
  // a lone high byte would pair with a stale low byte, so it is dropped
  assign commitTx      = (cpuWr & bus16 & hitTx) | (hitTxHigh8 & stagedPending);

  // In 8-bit mode only the low byte address read clears the flag,
  // so a byte-wise read of the register clears it once
  assign hitExpRead    = cpuRd & hitExp & (bus16 | wordAddr0);

  // Holds the low byte so the register never shows a half-written page
  anpcs_byte_stage u_stage (
    .clk        (clk),
    .rstn       (rstn),
    .lowWrite   (hitTxLow8),
    .highWrite  (hitTxHigh8),
    .byteIn     (cpuWrData[7:0]),
    .lowByte    (stagedLow),
    .lowPending (stagedPending)
  );

  // Full word to commit: 16-bit write directly, 8-bit from staged low plus high
  // In 8-bit mode the high byte arrives on the low lane, like the low byte did
  always_comb begin
    if (bus16) begin
      wrWord = cpuWrData;
    end else begin
      wrWord = {cpuWrData[7:0], stagedLow};
    end
  end

  // Word read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rdWord = 16'h0000;
    if (hitExp) begin
      rdWord[anpcs_pkg::NEXT_PAGE_RX_BIT]  = st.nextPageRx;
      rdWord[anpcs_pkg::NEXT_PAGE_ABL_BIT] = 1'b1; // Next pages always supported
      rdWord[anpcs_pkg::PAGE_RECEIVED_BIT] = st.pageReceived;
    end else if (hitTx) begin
      rdWord = st.npTransmit;
    end else if (hitPartner) begin
      rdWord = st.partnerNp;
    end else if (hitExtAbility) begin
      rdWord = anpcs_pkg::EXT_ABILITY_VALUE;
    end else if (hitStatus) begin
      rdWord = st.codingStat;
    end
  end

  // Byte lane for 8-bit reads: even address gives the low byte, odd the high byte
  always_comb begin
    if (bus16) begin
      laneWord = rdWord;
    end else if (wordAddr0) begin
      laneWord = {8'h00, rdWord[7:0]};
    end else begin
      laneWord = {8'h00, rdWord[15:8]};
    end
  end

  // Next state of the bank: writes, page capture, flag, toggle, status, read data
  always_comb begin
    next_st = st;

    // Masked commit: reserved bit 14 and the hardware toggle bit stay zero
    if (commitTx) begin
      next_st.npTransmit = wrWord & anpcs_pkg::NP_TRANSMIT_WMASK;
    end

    // Whole received page replaces the register in one edge
    // The next-page indication moves with the page, never ahead of it
    if (pageRxValid) begin
      next_st.partnerNp  = pageRxWord;
      next_st.nextPageRx = pageRxIsNext;
    end

    // Set wins over the clear-on-read in the same cycle
    if (pageRxValid) begin
      next_st.pageReceived = 1'b1;
    end else if (hitExpRead) begin
      next_st.pageReceived = 1'b0;
    end

    // Toggle seeded from the base page, then inverted per sent page
    // A seed and a sent page in one cycle re-seed, since start has priority
    if (exchangeStart) begin
      next_st.toggle = ~baseToggle;
    end else if (txPageSent) begin
      next_st.toggle = ~st.toggle;
    end

    // Status only tracks the link while in coding-sublayer mode
    // Outside that mode the bits read zero rather than stale link state
    next_st.codingStat = anpcs_pkg::CODING_STAT_RESET;
    if (gigabitCodingSublayer) begin
      next_st.codingStat[anpcs_pkg::SYNC_ACQUIRED_BIT] = syncAcquired;
      next_st.codingStat[anpcs_pkg::PARTNER_PAUSE_BIT] = partnerPauseStatus;
      next_st.codingStat[anpcs_pkg::RX_FLOW_CTRL_BIT]  = rxFlowControlStatus;
    end

    // Read data registered so it holds stable until the next read strobe
    if (cpuRd) begin
      next_st.rdData = laneWord;
    end
  end

  // Synchronous reset returns every register to its value after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st.npTransmit   <= anpcs_pkg::NP_TRANSMIT_RESET;
      st.partnerNp    <= anpcs_pkg::PARTNER_NP_RESET;
      st.codingStat   <= anpcs_pkg::CODING_STAT_RESET;
      st.pageReceived <= 1'b0;
      st.nextPageRx   <= 1'b0;
      st.toggle       <= 1'b0;
      st.rdData       <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  // Outgoing page: stored fields plus the hardware toggle in bit 11
  // Software never writes bit 11, so the toggle cannot be forced out of step
  always_comb begin
    txPage = st.npTransmit;
    txPage[anpcs_pkg::TOGGLE_BIT] = st.toggle;
  end

  assign cpuRdData = st.rdData;
endmodule
`default_nettype wire

// >>> verif/anpcs_regs_properties.sv
// Port checks on the next-page and status bank.
// Assumes status inputs hold steady around a status read.
`timescale 1ns/1ps
`default_nettype none
module anpcs_regs_properties (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        bus16,
  input wire logic [7:0]  cpuAddr,
  input wire logic [15:0] cpuWrData,
  input wire logic        cpuWr,
  input wire logic        cpuRd,
  input wire logic [15:0] cpuRdData,
  input wire logic        pageRxValid,
  input wire logic [15:0] pageRxWord,
  input wire logic        txPageSent,
  input wire logic        exchangeStart,
  input wire logic        baseToggle,
  input wire logic [15:0] txPage,
  input wire logic        gigabitCodingSublayer,
  input wire logic        syncAcquired,
  input wire logic        partnerPauseStatus,
  input wire logic        rxFlowControlStatus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Word accesses only; byte lanes are judged by the bench
  wire       rdX = cpuRd && bus16 && cpuAddr == 8'h6e;
  wire       rdS = cpuRd && bus16 && cpuAddr == 8'h70;
  wire       rdE = cpuRd && bus16 && cpuAddr == 8'h5c;
  wire       wrT = cpuWr && bus16 && cpuAddr == 8'h5e;
  wire [3:0] st  = {gigabitCodingSublayer, syncAcquired, partnerPauseStatus, rxFlowControlStatus};
  // A page arriving beside the read may legally re-arm the flag
  sequence quietRead;
    rdE && !pageRxValid;
  endsequence
  chk_ext_full: assert property (rdX |=> cpuRdData[15]) else $error("ext bit 15 low");
  chk_ext_zero: assert property (rdX |=> !cpuRdData[14:12]) else $error("ext 14:12 set");
  chk_stat_word: assert property (rdS && $stable(st) |=> cpuRdData ==
    ($past(st[3]) ? {10'h0, $past(st[2]), 3'h0, $past(st[1:0])} : 16'h0)) else $error("status");
  chk_tx_fields: assert property (wrT |=>
    (txPage & 16'hb7ff) == ($past(cpuWrData) & 16'hb7ff)) else $error("tx fields");
  chk_toggle_flip: assert property (txPageSent && !exchangeStart |=>
    txPage[11] != $past(txPage[11])) else $error("toggle kept");
  chk_toggle_seed: assert property (exchangeStart |=> txPage[11] == !$past(baseToggle))
    else $error("toggle seed");
  chk_rx_page: assert property (pageRxValid ##2 cpuRd && bus16 && cpuAddr == 8'h60 |=>
    cpuRdData == $past(pageRxWord, 3)) else $error("partner page");
  chk_flag_clear: assert property (quietRead ##1 !pageRxValid ##1 quietRead |=>
    !cpuRdData[1]) else $error("flag kept");
endmodule
bind anpcs_regs anpcs_regs_properties anpcs_regs_properties_i (.*);
`default_nettype wire

// >>> verif/anpcs_lp.sv
// Link-side model: partner pages and page exchange events.
// Assumes tasks are called from the bench's main sequence.
`timescale 1ns/1ps
`default_nettype none
module anpcs_lp (
  input  wire logic        clk,
  output logic             pageRxValid,
  output logic             pageRxIsNext,
  output logic             txPageSent,
  output logic             exchangeStart,
  output logic             baseToggle,
  output logic      [15:0] pageRxWord
);
  // Garbled word after the strobe drops, so stale data never matches
  initial {pageRxValid, pageRxIsNext, txPageSent, exchangeStart, baseToggle, pageRxWord} = '0;
  task automatic rxPage(input logic [15:0] w);
    @(posedge clk);
    {pageRxValid, pageRxIsNext, pageRxWord} <= {2'h3, w};
    @(posedge clk);
    {pageRxValid, pageRxWord} <= {1'h0, ~w};
  endtask
  // Seed from the base page, or report one exchanged page
  task automatic pulse(input logic start, input logic base);
    @(posedge clk);
    {exchangeStart, txPageSent, baseToggle} <= {start, !start, base};
    @(posedge clk);
    {exchangeStart, txPageSent} <= 2'h0;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_anpcs_regs.sv
// Bench for the register bank: CPU word and byte accesses.
// Assumes read data lands one cycle after the read edge.
`timescale 1ns/1ps
`default_nettype none
module tb_anpcs_regs;
  logic        clk = 1'h0;
  logic        rstn, bus16, cpuWr, cpuRd, pageRxValid, pageRxIsNext;
  logic        txPageSent, exchangeStart, baseToggle;
  logic [3:0]  stat;
  logic [7:0]  cpuAddr;
  logic [15:0] cpuWrData, cpuRdData, pageRxWord, txPage;
  int          errors = 0, testsRun = 0, cycles = 0;
  anpcs_regs anpcs_regs_i (.*, .gigabitCodingSublayer(stat[3]), .syncAcquired(stat[2]),
    .partnerPauseStatus(stat[1]), .rxFlowControlStatus(stat[0]));
  anpcs_lp anpcs_lp_i (.*);
  // 100 ns clock; a hang costs at most 3000 cycles
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) final_report(1);
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    testsRun++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w16);
    @(posedge clk);
    {bus16, cpuAddr, cpuWrData, cpuWr} <= {w16, a, d, 1'h1};
    @(posedge clk);
    cpuWr <= 1'h0;
  endtask
  // Read in either bus width; 8-bit reads return the addressed byte in [7:0]
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic w16);
    @(posedge clk);
    {bus16, cpuAddr, cpuRd} <= {w16, a, 1'h1};
    @(posedge clk);
    cpuRd <= 1'h0;
    @(negedge clk);
    chk($sformatf("reg %h", a), e, cpuRdData);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rd(a, e, 1'h1);
  endtask
  task automatic final_report(input int lost);
    errors += lost;
    $display("checks %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rstn, bus16, cpuAddr, cpuWrData, cpuWr, cpuRd, stat} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    rc(8'h5c, 16'h0004);
    wr(8'h6e, 16'h7fff, 1'h1);
    rc(8'h6e, 16'h8000);
    $display("test fixed done");
    wr(8'h5e, 16'hffff, 1'h1);
    rc(8'h5e, 16'hb7ff);
    anpcs_lp_i.pulse(1'h1, 1'h0);
    chk("txPage", 16'hbfff, txPage);
    anpcs_lp_i.pulse(1'h1, 1'h1);
    chk("txPage", 16'hb7ff, txPage);
    anpcs_lp_i.pulse(1'h0, 1'h0);
    chk("txPage", 16'hbfff, txPage);
    wr(8'h5e, 16'h00a5, 1'h0);
    wr(8'h5f, 16'h0012, 1'h0);
    wr(8'h5f, 16'h00ff, 1'h0);
    rc(8'h5e, 16'h12a5);
    rd(8'h5e, 16'h00a5, 1'h0);
    rd(8'h5f, 16'h0012, 1'h0);
    chk("txPage", 16'h1aa5, txPage);
    $display("test tx done");
    wr(8'h60, 16'hffff, 1'h1);
    rc(8'h60, 16'h0000);
    anpcs_lp_i.rxPage(16'ha801);
    rc(8'h60, 16'ha801);
    rd(8'h5d, 16'h0000, 1'h0);
    rc(8'h5c, 16'h0086);
    rc(8'h5c, 16'h0084);
    $display("test page done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      stat <= 4'(i);
      rc(8'h70, i[3] ? {10'h0, i[2], 3'h0, i[1:0]} : 16'h0);
    end
    $display("test status done");
    final_report(0);
  end
endmodule
`default_nettype wire
